// file: dbrw_pkg.sv
// constants and types shared by the refresh and write-recovery block
package dbrw_pkg;
    localparam int unsigned SYS_CLK_MHZ = 125;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned ROW_W = 12;
    localparam int unsigned LAT_W = 5;
    // internal refresh must start inside tCKE after entry
    localparam int unsigned T_CKE_NS = 5;
    localparam int unsigned TCKE_CYC_RAW = (T_CKE_NS * SYS_CLK_MHZ) / 1000;
    localparam int unsigned TCKE_CYC = (TCKE_CYC_RAW < 1) ? 1 : TCKE_CYC_RAW;
    // internal self-refresh timer, a plain default
    localparam int unsigned T_SREF_INT_NS = 7800;
    localparam int unsigned SREF_INT_CYC = (T_SREF_INT_NS * SYS_CLK_MHZ) / 1000;
    localparam logic [1:0] BURST_BL8 = 2'b00;
    localparam logic [1:0] BURST_OTF = 2'b01;
    localparam logic [1:0] BURST_BC4 = 2'b10;
    localparam logic [3:0] BEATS_BL8 = 4'h8;
    localparam logic [3:0] BEATS_BC4 = 4'h4;
    // command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    typedef enum logic [1:0] {
        DBRW_IDLE, DBRW_SREF, DBRW_XS
    } dbrw_state_type;
endpackage : dbrw_pkg

// file: dbrw_sync.sv
// two-flop synchroniser for one pin level
`timescale 1ns/1ns
`default_nettype none
module dbrw_sync (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic pin,
    output logic level
);
    logic stage;
    // first stage is read only by the second
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stage <= 1'b0;
            level <= 1'b0;
        end else begin
            stage <= pin;
            level <= stage;
        end
    end
endmodule : dbrw_sync
`default_nettype wire

// file: dbrw_core.sv
// dram-side refresh, self-refresh and write burst length / recovery logic
`timescale 1ns/1ns
`default_nettype none
module dbrw_core (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic a12,
    input wire logic [1:0] burst_mode,
    input wire logic dll_disable,
    input wire logic [dbrw_pkg::LAT_W-1:0] additive_latency,
    input wire logic [dbrw_pkg::LAT_W-1:0] cas_write_latency,
    output logic refresh_pulse,
    output logic [dbrw_pkg::ROW_W-1:0] refresh_row,
    output logic in_self_refresh,
    output logic dll_enabled,
    output logic dll_reset,
    output logic write_data_window,
    output logic write_recovery_start,
    output logic burst_chop
);
    import dbrw_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: every pin crosses two flops before use
    logic ck_s, cke_s, cs_s, ras_s, cas_s, we_s, a12_s;
    logic [6:0] pins_raw, pins_s;
    assign pins_raw = {ck, cke, cs_n, ras_n, cas_n, we_n, a12};
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_sync
            dbrw_sync u_sync (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .pin(pins_raw[gi]),
                .level(pins_s[gi])
            );
        end
    endgenerate
    assign {ck_s, cke_s, cs_s, ras_s, cas_s, we_s, a12_s} = pins_s;

    // beat count decode, used at write capture only for the chop flag
    function automatic logic [3:0] beats_of(input logic [1:0] mode,
                                            input logic a12_bit);
        if (mode == BURST_BC4)
            beats_of = BEATS_BC4;
        else if (mode == BURST_OTF && !a12_bit)
            beats_of = BEATS_BC4;
        else
            beats_of = BEATS_BL8;
    endfunction : beats_of

    ////////////////////////////////////////////////////////////////////
    // link clock edge detect and command decode on rising ck
    logic ck_d, cke_d;
    logic ck_rise, cmd_ref, cmd_sre, cmd_srx, cmd_wr;
    logic [3:0] cmd;
    assign ck_rise = ck_s && !ck_d;
    assign cmd = {cs_s, ras_s, cas_s, we_s};
    // cke_d is cke registered at previous ck edge
    assign cmd_ref = ck_rise && cke_d && cke_s && cmd == CMD_REF;
    assign cmd_sre = ck_rise && cke_d && !cke_s && cmd == CMD_REF;
    assign cmd_wr = ck_rise && cke_s && cmd == CMD_WRITE;

    ////////////////////////////////////////////////////////////////////
    // refresh / self-refresh state
    dbrw_state_type state, next_state;
    logic [CNT_W-1:0] timer, next_timer;
    logic [ROW_W-1:0] next_row;
    logic next_refresh, next_dll_en, next_dll_rst, next_cke_d;
    logic first_done, next_first_done;

    assign cmd_srx = ck_rise && cke_s; // exit sampled on any rising edge

    always_comb begin
        next_state = state;
        next_timer = timer;
        next_row = refresh_row;
        next_refresh = 1'b0;
        next_dll_en = dll_enabled;
        next_dll_rst = 1'b0;
        next_first_done = first_done;
        next_cke_d = ck_rise ? cke_s : cke_d;
        case (state)
            DBRW_IDLE: begin
                if (cmd_sre) begin
                    next_state = DBRW_SREF;
                    next_timer = '0;
                    next_first_done = 1'b0;
                    if (!dll_disable)
                        next_dll_en = 1'b0;
                end else if (cmd_ref) begin
                    // address bus ignored, row from counter
                    next_refresh = 1'b1;
                    next_row = refresh_row + 1'b1;
                end
            end
            DBRW_SREF: begin
                // command and address pins ignored here; cke sampled on rising ck
                next_timer = timer + 1'b1;
                if (!first_done && timer >= CNT_W'(TCKE_CYC - 1)) begin
                    next_refresh = 1'b1;
                    next_row = refresh_row + 1'b1;
                    next_first_done = 1'b1;
                    next_timer = '0;
                end else if (first_done &&
                             timer >= CNT_W'(SREF_INT_CYC - 1)) begin
                    next_refresh = 1'b1;
                    next_row = refresh_row + 1'b1;
                    next_timer = '0;
                end
                if (cmd_srx) begin
                    next_state = DBRW_XS;
                    if (!dll_disable) begin
                        next_dll_en = 1'b1;
                        next_dll_rst = 1'b1;
                    end
                end
            end
            DBRW_XS: begin
                // banks already precharged after any refresh
                next_state = DBRW_IDLE;
            end
            default: next_state = DBRW_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= DBRW_IDLE;
            timer <= '0;
            refresh_row <= '0;
            refresh_pulse <= 1'b0;
            dll_enabled <= 1'b1;
            dll_reset <= 1'b0;
            first_done <= 1'b0;
            cke_d <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            refresh_row <= next_row;
            refresh_pulse <= next_refresh;
            dll_enabled <= next_dll_en;
            dll_reset <= next_dll_rst;
            first_done <= next_first_done;
            cke_d <= next_cke_d;
        end
    end
    assign in_self_refresh = (state == DBRW_SREF);

    ////////////////////////////////////////////////////////////////////
    // write burst: latency count, beat count, recovery start
    // counts in ck cycles; one burst tracked at a time, a write during
    // a running burst restarts it (seamless back-to-back not modelled)
    logic [LAT_W:0] wl_cnt, next_wl_cnt;
    logic [3:0] beat_cnt, next_beat_cnt;
    logic next_window, next_rec, next_chop, ck_d_next;

    always_comb begin
        next_wl_cnt = wl_cnt;
        next_beat_cnt = beat_cnt;
        next_window = write_data_window;
        next_rec = 1'b0;
        next_chop = burst_chop;
        ck_d_next = ck_s;
        if (cmd_wr && state == DBRW_IDLE) begin
            // first beat at AL + CWL clocks
            next_wl_cnt = {1'b0, additive_latency} +
                          {1'b0, cas_write_latency};
            next_chop = (beats_of(burst_mode, a12_s) == BEATS_BC4);
            next_window = 1'b0;
            next_beat_cnt = '0;
        end else if (ck_rise) begin
            if (wl_cnt != '0) begin
                next_wl_cnt = wl_cnt - 1'b1;
                if (wl_cnt == (LAT_W+1)'(1)) begin
                    next_window = 1'b1;
                    // data clocks: four beats pair in two, eight in four;
                    // chopped recovery counts four clocks from first
                    next_beat_cnt = BEATS_BL8 >> 1;
                end
            end else if (write_data_window) begin
                next_beat_cnt = beat_cnt - 1'b1;
                if (beat_cnt == 4'h1) begin
                    next_window = 1'b0;
                    // recovery reference edge for tWR and tWTR
                    next_rec = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wl_cnt <= '0;
            beat_cnt <= '0;
            write_data_window <= 1'b0;
            write_recovery_start <= 1'b0;
            burst_chop <= 1'b0;
            ck_d <= 1'b0;
        end else begin
            wl_cnt <= next_wl_cnt;
            beat_cnt <= next_beat_cnt;
            write_data_window <= next_window;
            write_recovery_start <= next_rec;
            burst_chop <= next_chop;
            ck_d <= ck_d_next;
        end
    end
endmodule : dbrw_core
`default_nettype wire

// file: dbrw_core_props.sv
// assertion checker for the refresh and write-recovery block
`timescale 1ns/1ns
`default_nettype none
module dbrw_core_props (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic dll_disable,
    input wire logic refresh_pulse,
    input wire logic [dbrw_pkg::ROW_W-1:0] refresh_row,
    input wire logic in_self_refresh,
    input wire logic dll_enabled,
    input wire logic dll_reset,
    input wire logic write_data_window,
    input wire logic write_recovery_start
);
    import dbrw_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////
    // pulses stand one cycle; the row counter only ever steps by one
    a_ref_pulse_one: assert property (refresh_pulse |=>
        !refresh_pulse) else $error("refresh pulse longer than one cycle");
    a_row_steps_one: assert property ($changed(refresh_row) |->
        refresh_row == $past(refresh_row) + 1'b1) else $error("row skipped");
    a_dll_off_entry: assert property ($rose(in_self_refresh)
        && !dll_disable |-> ##[0:1] !dll_enabled)
        else $error("dll kept on in self-refresh");
    a_dll_reset_exit: assert property ($fell(in_self_refresh)
        && !dll_disable |-> ##[0:1] dll_reset)
        else $error("no dll reset at exit");
    a_sref_first_ref: assert property ($rose(in_self_refresh)
        |-> ##[0:3] refresh_pulse) else $error("no refresh after entry");
    a_dll_reset_one: assert property (dll_reset |=> !dll_reset)
        else $error("dll reset longer than one cycle");
    a_wrs_pulse_one: assert property (write_recovery_start |=>
        !write_recovery_start)
        else $error("recovery start longer than one cycle");
    a_wrs_at_end: assert property ($fell(write_data_window)
        |-> ##[0:1] write_recovery_start) else $error("recovery start missing");
    c_refresh: cover property (refresh_pulse);
    c_sref: cover property ($fell(in_self_refresh));
    c_write: cover property (write_recovery_start);
endmodule : dbrw_core_props
bind dbrw_core dbrw_core_props i_props (.sys_clk(sys_clk), .rstn(rstn),
    .dll_disable(dll_disable), .refresh_pulse(refresh_pulse),
    .refresh_row(refresh_row), .in_self_refresh(in_self_refresh),
    .dll_enabled(dll_enabled), .dll_reset(dll_reset),
    .write_data_window(write_data_window),
    .write_recovery_start(write_recovery_start));
`default_nettype wire

// file: dbrw_ctl_model.sv
// controller-side model: link clock and command pins
`timescale 1ns/1ns
`default_nettype none
module dbrw_ctl_model (
    input wire logic sys_clk,
    output logic ck,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic a12
);
    // clock runs on through self-refresh, so it is stable before exit
    initial begin
        ck = 1'b0;
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        a12 = 1'b0;
        #3;
        forever #80 ck = ~ck;
    end
    // one command on one ck rise, then NOP with a12 flipped to show release
    // used from idle and from self-refresh, NOP filler after it
    task automatic cmd(input logic [3:0] c, input logic ke, input logic ad);
        @(negedge ck);
        @(posedge sys_clk);
        {cs_n, ras_n, cas_n, we_n} <= c;
        cke <= ke;
        a12 <= ad;
        @(negedge ck);
        @(posedge sys_clk);
        {cs_n, ras_n, cas_n, we_n} <= 4'h7;
        a12 <= ~ad;
    endtask : cmd
endmodule : dbrw_ctl_model
`default_nettype wire

// file: test_dbrw_core.sv
// self-checking bench for the refresh and write-recovery block
`timescale 1ns/1ns
`default_nettype none
module test_dbrw_core;
    import dbrw_pkg::*;
    logic sys_clk = 1'b0, rstn = 1'b0, dll_disable = 1'b0, a;
    logic [1:0] burst_mode = 2'h0;
    logic [1:0] modes [4] = '{BURST_BL8, BURST_OTF, BURST_OTF, BURST_BC4};
    logic [LAT_W-1:0] al = 5'h00, cwl = 5'h05;
    logic ck, cke, cs_n, ras_n, cas_n, we_n, a12, refresh_pulse, dll_reset;
    logic in_self_refresh, dll_enabled, write_data_window;
    logic write_recovery_start, burst_chop;
    logic [ROW_W-1:0] refresh_row;
    int failures = 0, num_checks = 0, refs = 0, dres = 0, wins = 0, n, m, lat;
    logic win_d = 1'b0;
    // nop spacing in sys_clk cycles (8 ck) standing in for tRFC and tXS;
    // a plain default, kept generous since the device does not check it
    localparam int GAP = 160;
    always #4 sys_clk = ~sys_clk;
    dbrw_ctl_model i_ctl (.sys_clk(sys_clk), .ck(ck), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .a12(a12));
    dbrw_core i_dut (.sys_clk(sys_clk), .rstn(rstn), .ck(ck), .cke(cke),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .a12(a12),
        .burst_mode(burst_mode), .dll_disable(dll_disable),
        .additive_latency(al), .cas_write_latency(cwl),
        .refresh_pulse(refresh_pulse), .refresh_row(refresh_row),
        .in_self_refresh(in_self_refresh), .dll_enabled(dll_enabled),
        .dll_reset(dll_reset), .write_data_window(write_data_window),
        .write_recovery_start(write_recovery_start), .burst_chop(burst_chop));
    // event counters for the refresh and dll reset pulses and for data window openings
    always @(posedge sys_clk) begin
        refs <= refs + (refresh_pulse === 1'b1);
        dres <= dres + (dll_reset === 1'b1);
        wins <= wins + (write_data_window === 1'b1 && win_d !== 1'b1);
        win_d <= write_data_window;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    // bounded wait for the data window (s=0) or the recovery pulse (s=1)
    task automatic wait_on(input bit s, output int c);
        c = 0;
        while ((s ? write_recovery_start : write_data_window) !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            c++;
            if (c > 600) begin
                failures++;
                report_and_stop();
            end
        end
    endtask : wait_on
    // chop when forced by the mode, or on the fly with a12 low
    function automatic logic chop_of(input logic [1:0] md, input logic b);
        return md == BURST_BC4 || (md == BURST_OTF && !b);
    endfunction : chop_of
    initial begin
        n = $urandom(32'hdcd7e346);
        repeat (4) @(posedge sys_clk);
        chk("reset", 16'h0010, {refresh_pulse, in_self_refresh, dll_enabled,
            dll_reset, write_data_window, write_recovery_start, burst_chop});
        rstn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        // refresh with random address pins; rows come from the counter
        for (int k = 0; k < 3; k++) begin
            a = 1'($urandom_range(1));
            i_ctl.cmd(CMD_REF, 1'b1, a);
            // nop filler for tRFC before the next command
            repeat (GAP) @(posedge sys_clk);
            chk("refs", k + 1, refs);
            chk("row", k + 1, refresh_row);
        end
        // every burst mode, random latencies; no read or precharge follows
        for (int k = 0; k < 8; k++) begin
            a = (k % 4 == 1) ? 1'b0 : (k % 4 == 2) ? 1'b1 :
                1'($urandom_range(1));
            @(posedge sys_clk);
            burst_mode <= modes[k % 4];
            al <= (k == 0) ? 5'h00 : 5'($urandom_range(4));
            cwl <= (k == 0) ? 5'h05 : 5'($urandom_range(9, 5));
            @(posedge sys_clk);
            lat = (al + cwl) * 20 - 10;
            i_ctl.cmd(CMD_WRITE, 1'b1, a);
            wait_on(1'b0, n);
            chk("wlat", 1, n > lat - 7 && n < lat + 7);
            wait_on(1'b1, n);
            chk("wrec", 1, n > 73 && n < 87);
            chk("chop", chop_of(burst_mode, a), burst_chop);
        end
        // self-refresh with the dll enabled, then disabled
        for (int d = 0; d < 2; d++) begin
            // idle spacing so recovery and tRFC are met before entry
            repeat (GAP) @(posedge sys_clk);
            dll_disable <= d[0];
            n = refs;
            m = wins;
            i_ctl.cmd(CMD_REF, 1'b0, 1'b0); // entry, none postponed
            repeat (8) @(posedge sys_clk);
            chk("insr", 1, in_self_refresh);
            chk("sref", n + 1, refs);
            chk("dlloff", d[0], dll_enabled);
            i_ctl.cmd(CMD_WRITE, 1'b0, 1'b0);
            repeat (300) @(posedge sys_clk);
            chk("ignore", m, wins); // write ignored in self-refresh
            m = dres;
            i_ctl.cmd(4'h7, 1'b1, 1'b0);
            repeat (8) @(posedge sys_clk);
            chk("exit", 16'h0001, {in_self_refresh, dll_enabled});
            chk("dllrst", m + !d[0], dres);
            // only nop through tXS before the extra refresh
            repeat (GAP) @(posedge sys_clk);
            n = refs;
            i_ctl.cmd(CMD_REF, 1'b1, 1'b1); // extra refresh, no write after exit
            repeat (10) @(posedge sys_clk);
            chk("xref", n + 1, refs);
        end
        report_and_stop();
    end
endmodule : test_dbrw_core
`default_nettype wire
